// ---- usac_engine_ctrl.sv ----
// Address filter, transaction status and control overrides of the serial interface engine.
// Assumes a register port from the microcontroller on clk and engine signals on the same clock.
// What this block does
// [R1] Alternate-address tokens report the complemented endpoint number.
// [R2] Firmware keeps endpoint configurations from overlapping between addresses.
// [R3] Second alternate address, when enabled, unlocks endpoints 8 to 11.
// [R4] Third alternate address, when enabled, unlocks endpoints 12 to 15.
// [R5] A disabled alternate address never affects endpoint matching.
// [R6] Each alternate register holds a writable, readable seven-bit address.
// [R7] Status bit 7 flags an error in the last transaction.
// [R8] Status bit 6 flags an inter-packet gap above 16 bit times.
// [R9] Status bit 5 shows the last token was SETUP.
// [R10] Status bit 4 shows a start-of-frame token was received.
// [R11] Status bit 3 shows a valid SYNC plus PRE identifier was seen.
// [R12] Status bit 2 shows the last transaction had no error nor timeout.
// [R13] Status bit 1 is high while the bus is in reset.
// [R14] Status bit 0 rises at transaction end and falls at start.
// [R15] Status register is read-only and mirrors live engine state.
// [R16] Control bit 7 inhibits the engine buffer DMA path.
// [R17] Control bit 6 forces an acknowledge on receive; firmware keeps it clear.
// [R18] Control bit 5 tags the next transmit FIFO byte as last.
// [R19] Control bit 4 raises receive overflow and empties the receive FIFO.
// [R20] Control bit 3 aborts transmission with a bit-stuffing violation.
// [R21] Control bit 2 forces the current transaction to end.
// [R22] Control bits 1 and 0 are read-only receive tag and transmit success.
// [R23] Local address unlocks endpoints 0 to 3.
// [R24] First alternate address, when enabled, unlocks all sixteen endpoints.
// [R25] Bus reset is flagged after 32 bit times of single-ended zero.
// [R26] Endpoint match needs an address hit and an endpoint in its group.
`timescale 1ns/100ps
`default_nettype none
module usac_engine_ctrl
    import usac_pkg::*;
(
    input  wire logic        clk,              // System clock, 25 MHz
    input  wire logic        rst,              // Asynchronous reset, active high
    input  wire logic [15:0] reg_addr,         // Register byte address
    input  wire logic        reg_wr,           // Write strobe, one cycle
    input  wire logic        reg_rd,           // Read strobe, one cycle
    input  wire logic [7:0]  reg_wdata,        // Write data
    output logic [7:0]       reg_rdata,        // Read data, valid the cycle after reg_rd
    input  wire usac_token_t token,            // Decoded token, valid for one cycle
    input  wire logic        pre_seen,         // Pulse: valid SYNC then PRE identifier
    input  wire logic        bus_busy,         // Level: packet activity on the line
    input  wire logic        txn_done,         // Pulse: engine finished the transaction
    input  wire logic        txn_err,          // Error qualifier for txn_done
    input  wire logic        rx_packet_end_tag,// Receive FIFO packet-end tag
    input  wire logic        tx_success,       // Engine transmit success
    input  wire logic        tx_fifo_wr,       // Pulse: byte written to the transmit FIFO
    input  wire logic        se0_pin,          // Raw single-ended zero from the line
    output logic             endpoint_match,   // Registered: last token matched an endpoint
    output logic [3:0]       match_ep,         // Registered: endpoint as reported
    output logic             match_valid,      // Pulse: match result updated
    output usac_status_t     status,           // Live engine status
    output logic             engine_dma_inhibit, // Level: buffer DMA path held off
    output logic             force_receive_ack,  // Level: acknowledge regardless
    output logic             tx_last_byte,     // Pulse: this transmit FIFO write is the last byte
    output logic             receive_overflow, // Pulse: forced receive overflow
    output logic             rx_fifo_flush,    // Pulse: empty the receive FIFO
    output logic             stuff_violation   // Level: send bit-stuff errors
);
    usac_state_t  state;
    logic [7:0]   control;
    logic [7:0]   local_address;
    logic [7:0]   alias1;
    logic [7:0]   alias2;
    logic [7:0]   alias3;
    logic [6:0]   gap_cnt;
    logic         bus_reset;
    logic         force_end;
    logic         gap_over;
    logic         local_hit;
    logic         alt1_hit;
    logic         alt2_hit;
    logic         alt3_hit;
    logic         alt_hit;
    logic [7:0]   next_rdata;
    logic         st_err;
    logic         st_timeout;
    logic         st_setup;
    logic         st_sof;
    logic         st_pre;
    logic         st_ack;
    logic         st_eot;

    function automatic logic wr_hit(input logic [15:0] a);
        wr_hit = reg_wr && reg_addr == a;
    endfunction

    function automatic logic alias_hit(input logic [7:0] r, input logic [6:0] a);
        alias_hit = r[ALIAS_EN_BIT] && r[6:0] == a;
    endfunction

    usac_reset_detect u_reset_detect
    (
        .clk       (clk),
        .rst       (rst),
        .se0_pin   (se0_pin),
        .bus_reset (bus_reset)
    );

    // Address registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            local_address <= RST_ALIAS;
            alias1        <= RST_ALIAS;
            alias2        <= RST_ALIAS;
            alias3        <= RST_ALIAS;
        end
        else
        begin
            if (wr_hit(ADDR_LOCAL_ADDRESS))
                local_address <= reg_wdata;
            if (wr_hit(ADDR_FIRST_ALT))
                alias1 <= reg_wdata;
            if (wr_hit(ADDR_SECOND_ALT))
                alias2 <= reg_wdata; // see [R6]
            if (wr_hit(ADDR_THIRD_ALT))
                alias3 <= reg_wdata; // see [R6]
        end
    end

    // Overlapping groups are left to firmware; local wins, then any alternate, all ORed alike
    assign local_hit = token.addr == local_address[6:0] && token.ep <= EP_LOCAL_MAX; // see [R23] [R2]
    assign alt1_hit  = alias_hit(alias1, token.addr); // see [R24] [R5]
    assign alt2_hit  = alias_hit(alias2, token.addr)
                       && token.ep >= EP_SECOND_MIN && token.ep <= EP_SECOND_MAX; // see [R3] [R5]
    assign alt3_hit  = alias_hit(alias3, token.addr) && token.ep >= EP_THIRD_MIN; // see [R4] [R5]
    assign alt_hit   = alt1_hit || alt2_hit || alt3_hit;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            endpoint_match <= 1'b0;
            match_ep       <= 4'h0;
            match_valid    <= 1'b0;
        end
        else
        begin
            match_valid <= token.valid;
            if (token.valid)
            begin
                endpoint_match <= local_hit || alt_hit; // see [R26]
                if (local_hit)
                    match_ep <= token.ep;
                else if (alt_hit)
                    match_ep <= ~token.ep; // see [R1]
                else
                    match_ep <= token.ep;
            end
        end
    end

    // Control register; bits 1 and 0 are never stored
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            control <= RST_CONTROL;
        else if (wr_hit(ADDR_ENGINE_CONTROL))
            control <= reg_wdata & CTL_WRITABLE; // see [R22]
        else if (tx_fifo_wr && control[CTL_FORCE_LAST])
            control[CTL_FORCE_LAST] <= 1'b0; // see [R18]
    end

    assign engine_dma_inhibit = control[CTL_DMA_INHIBIT]; // see [R16]
    assign force_receive_ack  = control[CTL_FORCE_ACK];   // see [R17]
    assign stuff_violation    = control[CTL_FORCE_ABORT]; // see [R20]
    assign tx_last_byte       = tx_fifo_wr && control[CTL_FORCE_LAST]; // see [R18]
    // Written out so the assignment follows the strobe and address, not only the data
    assign force_end          = reg_wr && reg_addr == ADDR_ENGINE_CONTROL && reg_wdata[CTL_FORCE_END];

    // Overflow and flush fire on every write that sets the bit, so firmware can repeat it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            receive_overflow <= 1'b0;
            rx_fifo_flush    <= 1'b0;
        end
        else
        begin
            receive_overflow <= wr_hit(ADDR_ENGINE_CONTROL) && reg_wdata[CTL_FORCE_OVF]; // see [R19]
            rx_fifo_flush    <= wr_hit(ADDR_ENGINE_CONTROL) && reg_wdata[CTL_FORCE_OVF]; // see [R19]
        end
    end

    assign gap_over = gap_cnt == GAP_LAST && !bus_busy;

    // Transaction sequencing and end-of-transaction flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state      <= ST_IDLE;
            gap_cnt    <= 7'h00;
            st_eot     <= 1'b1;
            st_err     <= 1'b0;
            st_timeout <= 1'b0;
            st_ack     <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    gap_cnt <= 7'h00;
                    if (token.valid)
                    begin
                        state      <= ST_BUSY;
                        st_eot <= 1'b0; // see [R14]
                    end
                end
                ST_BUSY:
                begin
                    if (bus_busy)
                        gap_cnt <= 7'h00;
                    else if (!gap_over)
                        gap_cnt <= gap_cnt + 7'h01;
                    if (txn_done)
                    begin
                        state      <= ST_IDLE;
                        st_eot     <= 1'b1; // see [R14]
                        st_err     <= txn_err; // see [R7]
                        st_timeout <= 1'b0;
                        st_ack     <= !txn_err; // see [R12]
                    end
                    else if (force_end)
                    begin
                        state      <= ST_IDLE;
                        st_eot     <= 1'b1; // see [R21]
                        st_err     <= 1'b0;
                        st_timeout <= 1'b0;
                        st_ack     <= 1'b1;
                    end
                    else if (gap_over)
                    begin
                        state      <= ST_IDLE;
                        st_eot     <= 1'b1;
                        st_err     <= 1'b0;
                        st_timeout <= 1'b1; // see [R8]
                        st_ack     <= 1'b0; // see [R12]
                    end
                end
            endcase
        end
    end

    // Token kind flags follow each received token
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_setup <= 1'b0;
            st_sof   <= 1'b0;
        end
        else if (token.valid)
        begin
            st_setup <= token.is_setup; // see [R9]
            st_sof   <= token.is_sof;   // see [R10]
        end
    end

    // Preamble flag holds until the next token; a PRE in the same cycle as a token wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_pre <= 1'b0;
        else if (pre_seen)
            st_pre <= 1'b1; // see [R11]
        else if (token.valid)
            st_pre <= 1'b0;
    end

    assign status = {st_err, st_timeout, st_setup, st_sof, st_pre, st_ack, bus_reset, st_eot}; // see [R13] [R15]

    // Read mux; status writes are ignored
    always_comb
    begin
        next_rdata = UNMAPPED_READ;
        unique case (reg_addr)
            ADDR_ENGINE_STATUS:  next_rdata = status; // see [R15]
            ADDR_ENGINE_CONTROL: next_rdata = {control[7:2], rx_packet_end_tag, tx_success}; // see [R22]
            ADDR_LOCAL_ADDRESS:  next_rdata = local_address;
            ADDR_FIRST_ALT:      next_rdata = alias1;
            ADDR_SECOND_ALT:     next_rdata = alias2; // see [R6]
            ADDR_THIRD_ALT:      next_rdata = alias3; // see [R6]
            default:             next_rdata = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= UNMAPPED_READ;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    a_alt_ep_complement: assert property (@(posedge clk) disable iff (rst) // see [R1]
        token.valid && !local_hit && alt_hit |=> endpoint_match && match_ep == ~$past(token.ep))
        else $error("alternate endpoint not complemented");

    a_second_group: assert property (@(posedge clk) disable iff (rst) // see [R3]
        token.valid && !local_hit && !alt1_hit && !alt3_hit && alias2[ALIAS_EN_BIT]
        && token.addr == alias2[6:0] && token.ep < EP_SECOND_MIN |=> !endpoint_match)
        else $error("second alternate matched outside its group");

    a_third_group: assert property (@(posedge clk) disable iff (rst) // see [R4]
        token.valid && alias3[ALIAS_EN_BIT] && token.addr == alias3[6:0] && token.ep >= EP_THIRD_MIN
        |=> endpoint_match)
        else $error("third alternate failed to match its group");

    a_disabled_silent: assert property (@(posedge clk) disable iff (rst) // see [R5]
        token.valid && token.addr != local_address[6:0] && !alias1[ALIAS_EN_BIT]
        && !alias2[ALIAS_EN_BIT] && !alias3[ALIAS_EN_BIT] |=> !endpoint_match)
        else $error("disabled alternate address produced a match");

    a_eot_start: assert property (@(posedge clk) disable iff (rst) // see [R14]
        state == ST_IDLE && token.valid |=> !status.end_of_transaction_flag ##0 state == ST_BUSY)
        else $error("transaction start did not clear end flag");

    a_gap_timeout: assert property (@(posedge clk) disable iff (rst) // see [R8]
        state == ST_BUSY && !txn_done && !force_end && !bus_busy ##1
        (!bus_busy && !txn_done && !force_end && state == ST_BUSY)[*8] |-> ##[0:30] status.end_of_transaction_flag || bus_busy
        || txn_done || force_end)
        else $error("idle gap did not end the transaction in time");

    a_ack_exclusive: assert property (@(posedge clk) disable iff (rst) // see [R12]
        $rose(status.end_of_transaction_flag) |-> status.ack == !(status.err || status.timeout))
        else $error("acknowledge inconsistent with error and timeout");

    a_force_end: assert property (@(posedge clk) disable iff (rst) // see [R21]
        state == ST_BUSY && force_end && !txn_done |=> status.end_of_transaction_flag && status.ack && state == ST_IDLE)
        else $error("forced end did not conclude the transaction");

    a_overflow_pulse: assert property (@(posedge clk) disable iff (rst) // see [R19]
        wr_hit(ADDR_ENGINE_CONTROL) && reg_wdata[CTL_FORCE_OVF] |=> receive_overflow && rx_fifo_flush)
        else $error("forced overflow not raised");

    a_last_byte_once: assert property (@(posedge clk) disable iff (rst) // see [R18]
        tx_last_byte && !wr_hit(ADDR_ENGINE_CONTROL) |=> !control[CTL_FORCE_LAST])
        else $error("last byte tag not consumed");

    a_pre_flag: assert property (@(posedge clk) disable iff (rst) // see [R11]
        pre_seen |=> status.pre)
        else $error("preamble not flagged");

endmodule
`default_nettype wire

// ---- usac_pkg.sv ----
// Constants, types and register map of the address filter, status and control block.
// Assumes a 25 MHz system clock and a full-speed (12 Mbit/s) bus.
package usac_pkg;

    // Register byte addresses on the microcontroller register port
    localparam logic [15:0] ADDR_ENGINE_STATUS  = 16'h7F93;
    localparam logic [15:0] ADDR_ENGINE_CONTROL = 16'h7F94;
    localparam logic [15:0] ADDR_LOCAL_ADDRESS  = 16'h7F92;
    localparam logic [15:0] ADDR_FIRST_ALT      = 16'h7F99;
    localparam logic [15:0] ADDR_SECOND_ALT     = 16'h7F9E;
    localparam logic [15:0] ADDR_THIRD_ALT      = 16'h7F9F;

    // Reset values
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_ALIAS     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Alternate address register fields
    localparam int ALIAS_EN_BIT = 7;

    // Control register fields
    localparam int CTL_DMA_INHIBIT   = 7;
    localparam int CTL_FORCE_ACK     = 6;
    localparam int CTL_FORCE_LAST    = 5;
    localparam int CTL_FORCE_OVF     = 4;
    localparam int CTL_FORCE_ABORT   = 3;
    localparam int CTL_FORCE_END     = 2;
    localparam int CTL_RX_TAG        = 1;
    localparam int CTL_TX_OK         = 0;
    localparam logic [7:0] CTL_WRITABLE = 8'hFC;

    // Endpoint groups
    localparam logic [3:0] EP_LOCAL_MAX  = 4'h3;
    localparam logic [3:0] EP_SECOND_MIN = 4'h8;
    localparam logic [3:0] EP_SECOND_MAX = 4'hB;
    localparam logic [3:0] EP_THIRD_MIN  = 4'hC;

    // Timing
    localparam longint CLK_HZ          = 25000000;
    localparam longint BIT_HZ          = 12000000;
    localparam longint GAP_BIT_TIMES   = 16;
    localparam longint RESET_BIT_TIMES = 32;
    // A gap is a timeout only once it exceeds the bit times, so round up
    localparam int GAP_CYC   = int'((GAP_BIT_TIMES * CLK_HZ + BIT_HZ - 1) / BIT_HZ);
    localparam int RESET_CYC = int'((RESET_BIT_TIMES * CLK_HZ + BIT_HZ - 1) / BIT_HZ);
    localparam logic [6:0] GAP_LAST   = 7'(GAP_CYC - 1);
    localparam logic [6:0] RESET_LAST = 7'(RESET_CYC - 1);

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } usac_state_t;

    // Decoded token from the packet receiver
    typedef struct packed
    {
        logic       valid;
        logic [6:0] addr;
        logic [3:0] ep;
        logic       is_setup;
        logic       is_sof;
    } usac_token_t;

    // Engine status byte, bit 7 down to bit 0
    typedef struct packed
    {
        logic err;
        logic timeout;
        logic setup;
        logic sof;
        logic pre;
        logic ack;
        logic bus_reset;
        logic end_of_transaction_flag;
    } usac_status_t;

endpackage

// ---- usac_reset_detect.sv ----
// Bus reset detector: single-ended zero held long enough on the line.
// Assumes se0 comes straight from the transceiver pin, asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module usac_reset_detect
    import usac_pkg::*;
(
    input  wire logic clk,       // System clock
    input  wire logic rst,       // Asynchronous reset, active high
    input  wire logic se0_pin,   // Raw single-ended zero from the line
    output logic      bus_reset  // High while the line is being reset
);
    logic [2:0] sync;
    logic       se0_level;
    logic [6:0] run;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sync <= 3'h0;
        else
            sync <= {sync[1:0], se0_pin};
    end

    // Level follows only once the second and third stages agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            se0_level <= 1'b0;
        else if (sync[1] == sync[2])
            se0_level <= sync[2];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run       <= 7'h00;
            bus_reset <= 1'b0;
        end
        else if (!se0_level)
        begin
            run       <= 7'h00;
            bus_reset <= 1'b0;
        end
        else if (run == RESET_LAST)
            bus_reset <= 1'b1; // see [R25] [R13]
        else
            run <= run + 7'h01;
    end

    a_reset_needs_run: assert property (@(posedge clk) disable iff (rst) // see [R25]
        $rose(bus_reset) |-> $past(se0_level, 1) && $past(run, 1) == RESET_LAST)
        else $error("bus reset raised before the single-ended zero lasted long enough");

endmodule
`default_nettype wire

// ---- usac_host_model.sv ----
// Host side model: tokens, packet activity, transaction end and line SE0.
// Assumes the bench calls its tasks just after a falling edge of clk.
`timescale 1ns/100ps
`default_nettype none
module usac_host_model
    import usac_pkg::*;
(
    input  wire logic  clk,      // System clock
    output usac_token_t token,   // Decoded token, one-cycle pulse
    output logic       pre_seen, // Preamble pulse
    output logic       bus_busy, // Packet activity level
    output logic       txn_done, // Transaction end pulse
    output logic       txn_err,  // Error qualifier of txn_done
    output logic       se0_pin   // Line single-ended zero
);
    initial
    begin
        token = '0;
        pre_seen = 1'b0;
        bus_busy = 1'b0;
        txn_done = 1'b0;
        txn_err = 1'b1;
        se0_pin = 1'b0;
    end

    task automatic send_token(input logic [6:0] a, input logic [3:0] e, input logic s, input logic f);
        token = '{1'b1, a, e, s, f};
        bus_busy = 1'b1;
        @(negedge clk);
        token = '0;
        bus_busy = 1'b0;
    endtask

    // Qualifier flips after the pulse so a stale value is never read as valid
    task automatic end_txn(input logic err);
        txn_done = 1'b1;
        txn_err = err;
        @(negedge clk);
        txn_done = 1'b0;
        txn_err = ~err;
    endtask

    task automatic pulse_pre();
        pre_seen = 1'b1;
        @(negedge clk);
        pre_seen = 1'b0;
    endtask

    task automatic hold_se0(input logic v);
        se0_pin = v;
    endtask
endmodule
`default_nettype wire

// ---- tb_usac_engine_ctrl.sv ----
// Self-checking bench for the address filter, status and control block.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_usac_engine_ctrl
    import usac_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [15:0]  reg_addr = '0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_wdata = '0;
    logic [7:0]   reg_rdata;
    usac_token_t  token;
    logic         pre_seen, bus_busy, txn_done, txn_err, se0_pin;
    logic         rx_tag = 1'b0;
    logic         tx_ok = 1'b0;
    logic         tx_fifo_wr = 1'b0;
    logic         endpoint_match, match_valid, dma_inh, fack, tx_last, rovf, rflush, stuff;
    logic [3:0]   match_ep;
    usac_status_t status;
    logic         ovf_seen = 1'b0;
    logic [7:0]   rv;
    int           num_errors = 0;
    int           n_tests = 0;
    int           cyc = 0;

    always #20 clk = ~clk;

    usac_host_model usac_host_model_inst (.clk(clk), .token(token), .pre_seen(pre_seen), .bus_busy(bus_busy),
        .txn_done(txn_done), .txn_err(txn_err), .se0_pin(se0_pin));

    usac_engine_ctrl usac_engine_ctrl_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .token(token), .pre_seen(pre_seen),
        .bus_busy(bus_busy), .txn_done(txn_done), .txn_err(txn_err), .rx_packet_end_tag(rx_tag),
        .tx_success(tx_ok), .tx_fifo_wr(tx_fifo_wr), .se0_pin(se0_pin), .endpoint_match(endpoint_match),
        .match_ep(match_ep), .match_valid(match_valid), .status(status), .engine_dma_inhibit(dma_inh),
        .force_receive_ack(fack), .tx_last_byte(tx_last), .receive_overflow(rovf), .rx_fifo_flush(rflush),
        .stuff_violation(stuff));

    // Both pulses share one timing, so they are caught together
    always @(posedge clk)
        if (rovf === 1'b1 && rflush === 1'b1)
            ovf_seen <= 1'b1;

    task automatic complete_run();
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // Idle cycle so a following write never redrives the strobe in the same step
        @(negedge clk);
    endtask

    // Waits past the answer edge; read data holds until the next read
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        check(what, reg_rdata, exp);
    endtask

    task automatic chk_tok(input logic [6:0] a, input logic [3:0] e, input logic m, input logic [3:0] rep);
        usac_host_model_inst.send_token(a, e, 1'b0, 1'b0);
        check("match", {match_valid, endpoint_match, 2'b00, match_ep}, {1'b1, m, 2'b00, rep});
        @(negedge clk);
    endtask

    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        rd_chk("ctl rst", ADDR_ENGINE_CONTROL, 8'h00);
        rd_chk("alt2 rst", ADDR_SECOND_ALT, 8'h00);
        rd_chk("alt3 rst", ADDR_THIRD_ALT, 8'h00);
        wr(ADDR_ENGINE_STATUS, 8'hFF);
        rd_chk("status ro", ADDR_ENGINE_STATUS, 8'h01);
        rd_chk("unmapped", 16'h7F9A, 8'h00);
        wr(ADDR_LOCAL_ADDRESS, 8'h03);
        wr(ADDR_SECOND_ALT, 8'h85);
        wr(ADDR_THIRD_ALT, 8'h86);
        rd_chk("alt2", ADDR_SECOND_ALT, 8'h85);
        rd_chk("alt3", ADDR_THIRD_ALT, 8'h86);
        chk_tok(7'h03, 4'h2, 1'b1, 4'h2);
        chk_tok(7'h03, 4'h4, 1'b0, 4'h4);
        chk_tok(7'h05, 4'h8, 1'b1, 4'h7);
        chk_tok(7'h05, 4'hB, 1'b1, 4'h4);
        chk_tok(7'h05, 4'hC, 1'b0, 4'hC);
        chk_tok(7'h05, 4'h7, 1'b0, 4'h7);
        chk_tok(7'h06, 4'hF, 1'b1, 4'h0);
        chk_tok(7'h06, 4'h8, 1'b0, 4'h8);
        wr(ADDR_THIRD_ALT, 8'h06);
        chk_tok(7'h06, 4'hF, 1'b0, 4'hF);
        wr(ADDR_SECOND_ALT, 8'h05);
        chk_tok(7'h05, 4'h8, 1'b0, 4'h8);
        wr(ADDR_FIRST_ALT, 8'h87);
        chk_tok(7'h07, 4'h0, 1'b1, 4'hF);
        usac_host_model_inst.end_txn(1'b0);
        @(negedge clk);
        usac_host_model_inst.send_token(7'h03, 4'h0, 1'b1, 1'b0);
        check("setup", status, 8'h24);
        usac_host_model_inst.pulse_pre();
        usac_host_model_inst.end_txn(1'b1);
        @(negedge clk);
        check("err end", status, 8'hA9);
        usac_host_model_inst.send_token(7'h03, 4'h1, 1'b0, 1'b1);
        check("sof", status, 8'h90);
        usac_host_model_inst.end_txn(1'b0);
        @(negedge clk);
        check("ack end", status, 8'h15);
        usac_host_model_inst.send_token(7'h03, 4'h1, 1'b0, 1'b0);
        repeat (33) @(negedge clk);
        check("gap short", status, 8'h04);
        @(negedge clk);
        check("gap end", status, 8'h41);
        usac_host_model_inst.send_token(7'h03, 4'h1, 1'b0, 1'b0);
        wr(ADDR_ENGINE_CONTROL, 8'h04);
        check("forced end", status, 8'h05);
        rx_tag = 1'b1;
        wr(ADDR_ENGINE_CONTROL, 8'hFF);
        rd_chk("ctl", ADDR_ENGINE_CONTROL, 8'hFE);
        check("ctl out", {4'h0, dma_inh, fack, stuff, ovf_seen}, 8'h0F);
        tx_fifo_wr = 1'b1;
        #1 check("last", {7'h00, tx_last}, 8'h01);
        @(negedge clk);
        tx_fifo_wr = 1'b0;
        @(negedge clk);
        tx_fifo_wr = 1'b1;
        #1 check("last once", {7'h00, tx_last}, 8'h00);
        @(negedge clk);
        tx_fifo_wr = 1'b0;
        tx_ok = 1'b1;
        rd_chk("ctl used", ADDR_ENGINE_CONTROL, 8'hDF);
        wr(ADDR_ENGINE_CONTROL, 8'h00);
        check("ctl clr", {5'h00, dma_inh, fack, stuff}, 8'h00);
        usac_host_model_inst.hold_se0(1'b1);
        repeat (66) @(negedge clk);
        check("se0 short", {7'h00, status.bus_reset}, 8'h00);
        repeat (14) @(negedge clk);
        check("bus reset", {7'h00, status.bus_reset}, 8'h01);
        usac_host_model_inst.hold_se0(1'b0);
        repeat (8) @(negedge clk);
        check("reset gone", {7'h00, status.bus_reset}, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
